// file: pie_pkg.sv
package pie_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int PIE_NSRC = 20;
    localparam int PIE_NLVL = 7;
    // ----------------------------------------
    // Register indices, byte address is four times
    // ----------------------------------------
    localparam logic [16:0] PIE_IDX_SYSVEC = 17'h0701E;
    localparam logic [16:0] PIE_IDX_GRPB = 17'h07433;
    localparam logic [16:0] PIE_IDX_GRPC = 17'h07434;
    localparam logic [16:0] PIE_IDX_GMASK = 17'h00010;
    localparam logic [16:0] PIE_IDX_LMASK = 17'h00011;
    localparam logic [16:0] PIE_IDX_SRCEN = 17'h00012;
    localparam logic [16:0] PIE_IDX_PEND = 17'h00013;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int PIE_GMASK_POS = 0;
    localparam logic PIE_GMASK_RST = 1'b1;
    localparam logic [6:0] PIE_LMASK_RST = 7'h00;
    localparam logic [19:0] PIE_SRCEN_RST = 20'h00000;
    localparam logic [15:0] PIE_VEC_RST = 16'h0000;
    localparam logic [1:0] PIE_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIE_RESP_SLVERR = 2'h2;
    // ----------------------------------------
    // Vectors
    // ----------------------------------------
    localparam logic [15:0] PIE_PHANTOM = 16'h0000;
    localparam logic [15:0] PIE_TRAP_VEC = 16'h0022;
    localparam logic [15:0] PIE_SWI_BASE = 16'h0010;
    localparam logic [4:0] PIE_SWI_FIRST = 5'h08;
    localparam logic [4:0] PIE_SWI_LAST = 5'h10;
    localparam logic [2:0] PIE_LVL_GRPB = 3'h3;
    localparam logic [2:0] PIE_LVL_GRPC = 3'h4;
    localparam logic [2:0] PIE_LVL_SYS_LO = 3'h5;
    localparam logic [2:0] PIE_LVL_SYS_HI = 3'h6;
    localparam logic [15:0] PIE_LVL_VEC [PIE_NLVL] = '{16'h0002, 16'h0004, 16'h0006,
        16'h0008, 16'h000A, 16'h000C, 16'h000E};
    // Sources in overall priority order, best first
    localparam logic [2:0] PIE_SRC_LVL [PIE_NSRC] = '{3'h3, 3'h3, 3'h3, 3'h3, // see RULE_05
        3'h3, 3'h3, 3'h3, 3'h3, // see RULE_06
        3'h4, 3'h4, 3'h4, 3'h4, // see RULE_07
        3'h5, 3'h5, 3'h5, // see RULE_08
        3'h6, 3'h6, 3'h6, 3'h6, // see RULE_09 see RULE_10
        3'h7}; // see RULE_11
    localparam logic [15:0] PIE_SRC_OFF [PIE_NSRC] = '{16'h002B, 16'h002C, 16'h002D,
        16'h002E, 16'h002F, 16'h0030, 16'h0031, 16'h0032, 16'h0033, 16'h0034,
        16'h0035, 16'h0036, 16'h0005, 16'h0006, 16'h0007, 16'h0004, 16'h0001,
        16'h0011, 16'h001F, 16'h0000};
    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {logic valid; logic [2:0] level;} pie_ack_t;
    typedef struct packed {logic valid; logic trap; logic [4:0] num;} pie_sw_t;
    typedef struct packed {logic valid; logic [15:0] addr;} pie_branch_t;
endpackage

// file: pie_pick.sv
`timescale 1ns/10ps
module pie_pick
    import pie_pkg::*;
(
    // Requests, index 0 best
    input wire logic [PIE_NSRC-1:0] req,
    // One-hot winner
    output logic [PIE_NSRC-1:0] grant,
    output logic any
);
    // ----------------------------------------
    // Lowest set bit wins
    // ----------------------------------------
    assign grant = req & (~req + 20'h00001); // see RULE_20
    assign any = |req;
endmodule

// file: pie_expander.sv
// How it works
// RULE_01: Each interrupt is requested, then acknowledged, then branched to its vector.
// RULE_02: Requests come from software or from pins and on-chip peripherals.
// RULE_03: Software and trap requests act at once; maskable ones need their enables. The code drops them when an acknowledge comes in the same cycle.
// RULE_04: After acknowledge the fixed vector location of the interrupt is issued.
// RULE_05: Timer-2 events use level 3, priorities 22-25, offsets 002Bh-002Eh.
// RULE_06: Timer-3 events use level 3, priorities 26-29, offsets 002Fh-0032h, group B.
// RULE_07: Captures 1-4 use level 4, priorities 30-33, offsets 0033h-0036h, group C.
// RULE_08: Serial, receiver, transmitter use level 5, offsets 0005h-0007h, system register.
// RULE_09: Converter done uses level 6, priority 37, offset 0004h, system register.
// RULE_10: External pins 1-3 use level 6, offsets 0001h, 0011h, 001Fh.
// RULE_11: Analysis interrupt is maskable, priority 41, vector 000Eh.
// RULE_12: Trap vectors to 0022h, unranked and unmasked.
// RULE_13: A phantom offset 0000h stands in for a real source offset.
// RULE_14: Software interrupts 8-16 vector to 0010h-0020h, unranked and unmasked.
// RULE_15: This block merges peripheral requests onto the maskable core levels.
// RULE_16: Global mask bit at 1 blocks all maskable requests.
// RULE_17: A level is serviced only while its level enable bit is 1.
// RULE_18: Global mask is set by reset and by every acknowledge except trap.
// RULE_19: Acknowledge with no answering source loads the phantom offset.
// RULE_20: Best pending enabled source of the acked level loads offset, gets cleared.
// RULE_21: A level request stands while an enabled mapped source is pending.
// RULE_22: Core gives a one-cycle level acknowledge, reads the vector after it.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module pie_expander
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Peripheral and pin sources
    input wire logic timer2_period_irq,
    input wire logic timer2_compare_irq,
    input wire logic timer2_underflow_irq,
    input wire logic timer2_overflow_irq,
    input wire logic timer3_period_irq,
    input wire logic timer3_compare_irq,
    input wire logic timer3_underflow_irq,
    input wire logic timer3_overflow_irq,
    input wire logic capture1_irq,
    input wire logic capture2_irq,
    input wire logic capture3_irq,
    input wire logic capture4_irq,
    input wire logic serial_periph_irq,
    input wire logic receiver_irq,
    input wire logic transmitter_irq,
    input wire logic converter_done_irq,
    input wire logic ext_pin1_irq,
    input wire logic ext_pin2_irq,
    input wire logic ext_pin3_irq,
    input wire logic analysis_irq,
    // Core side
    input wire pie_pkg::pie_ack_t ack,
    input wire pie_pkg::pie_sw_t sw,
    output logic [6:0] level_req,
    output pie_pkg::pie_branch_t branch,
    output logic global_mask_bit,
    // AXI4-Lite
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);
    import pie_pkg::*;

    // ----------------------------------------
    // Sources and pending flags
    // ----------------------------------------
    wire [PIE_NSRC-1:0] src_in = {analysis_irq, ext_pin3_irq, ext_pin2_irq, ext_pin1_irq,
        converter_done_irq, transmitter_irq, receiver_irq, serial_periph_irq,
        capture4_irq, capture3_irq, capture2_irq, capture1_irq,
        timer3_overflow_irq, timer3_underflow_irq, timer3_compare_irq, timer3_period_irq,
        timer2_overflow_irq, timer2_underflow_irq, timer2_compare_irq,
        timer2_period_irq}; // see RULE_02
    logic [PIE_NSRC-1:0] pend_reg;
    logic [PIE_NSRC-1:0] srcen_reg;
    logic [6:0] lmask_reg;
    logic gmask_reg;
    logic [15:0] sysvec_reg;
    logic [15:0] grpb_reg;
    logic [15:0] grpc_reg;
    wire [PIE_NSRC-1:0] live = pend_reg & srcen_reg;
    wire [PIE_NSRC-1:0] lvl_map [1:PIE_NLVL];
    wire [15:0] off_term [PIE_NSRC];
    wire [PIE_NSRC-1:0] grant;
    wire win_any;

    genvar gi;
    genvar gl;
    generate
        for (gl = 1; gl <= PIE_NLVL; gl++)
        begin : g_lvl
            for (gi = 0; gi < PIE_NSRC; gi++)
            begin : g_map
                assign lvl_map[gl][gi] = PIE_SRC_LVL[gi] == 3'(gl);
            end
        end
        for (gi = 0; gi < PIE_NSRC; gi++)
        begin : g_off
            assign off_term[gi] = grant[gi] ? PIE_SRC_OFF[gi] : 16'h0000;
        end
    endgenerate

    // ----------------------------------------
    // Acknowledge decode
    // ----------------------------------------
    wire ack_ok = ce && ack.valid && ack.level != 3'h0; // see RULE_22
    wire [PIE_NSRC-1:0] ack_map = (ack.level == 3'h0) ? '0 : lvl_map[ack.level];
    wire [PIE_NSRC-1:0] sel_req = ack_ok ? (live & ack_map) : '0;
    wire sw_go = ce && sw.valid && !ack_ok; // see RULE_03
    wire swi_in = sw.num >= PIE_SWI_FIRST && sw.num <= PIE_SWI_LAST;
    wire [4:0] swi_rel = sw.num - PIE_SWI_FIRST;
    wire [15:0] swi_addr = PIE_SWI_BASE + {10'h000, swi_rel, 1'b0}; // see RULE_14
    wire sw_fire = sw_go && (sw.trap || swi_in);

    pie_pick u_pick
    (
        .req(sel_req),
        .grant(grant),
        .any(win_any)
    );

    logic [15:0] off_sel;
    always_comb
    begin
        off_sel = 16'h0000;
        for (int i = 0; i < PIE_NSRC; i++)
        begin
            off_sel = off_sel | off_term[i];
        end
    end
    // No answering source leaves the phantom offset
    wire [15:0] vec_load = win_any ? off_sel : PIE_PHANTOM; // see RULE_19 see RULE_13
    wire load_b = ack_ok && ack.level == PIE_LVL_GRPB; // see RULE_05 see RULE_06
    wire load_c = ack_ok && ack.level == PIE_LVL_GRPC; // see RULE_07
    wire load_sys = ack_ok && (ack.level == PIE_LVL_SYS_LO
        || ack.level == PIE_LVL_SYS_HI); // see RULE_08 see RULE_09 see RULE_10

    // ----------------------------------------
    // Level requests
    // ----------------------------------------
    wire [6:0] lvl_next;
    generate
        for (gl = 1; gl <= PIE_NLVL; gl++)
        begin : g_req
            // Levels 1 and 2 carry no sources here and stay low
            assign lvl_next[gl-1] = !gmask_reg && lmask_reg[gl-1]
                && |(live & lvl_map[gl]); // see RULE_15 see RULE_16 see RULE_17 see RULE_21
        end
    endgenerate

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [31:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    wire aw_fire = awvalid && awready;
    wire w_fire = wvalid && wready;
    wire aw_have = aw_hold_reg || aw_fire;
    wire w_have = w_hold_reg || w_fire;
    wire do_wr = aw_have && w_have;
    wire [31:0] wa = aw_fire ? awaddr : awaddr_reg;
    wire [31:0] wd = w_fire ? wdata : wdata_reg;
    wire [3:0] ws = w_fire ? wstrb : wstrb_reg;
    wire [31:0] wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wire wa_ok = wa[31:19] == 13'h0000 && wa[1:0] == 2'b00;
    wire wr_gmask = do_wr && wa_ok && wa[18:2] == PIE_IDX_GMASK;
    wire wr_lmask = do_wr && wa_ok && wa[18:2] == PIE_IDX_LMASK;
    wire wr_srcen = do_wr && wa_ok && wa[18:2] == PIE_IDX_SRCEN;
    // Vector and pending registers are read-only, writes ignored
    wire wr_ro = do_wr && wa_ok && (wa[18:2] == PIE_IDX_SYSVEC
        || wa[18:2] == PIE_IDX_GRPB || wa[18:2] == PIE_IDX_GRPC
        || wa[18:2] == PIE_IDX_PEND);
    wire wr_hit = wr_gmask || wr_lmask || wr_srcen || wr_ro;
    wire [31:0] gm_old = {31'h0, gmask_reg};
    wire [31:0] gm_new = (gm_old & ~wmask) | (wd & wmask);
    wire [31:0] lm_new = ({25'h0, lmask_reg} & ~wmask) | (wd & wmask);
    wire [31:0] se_new = ({12'h000, srcen_reg} & ~wmask) | (wd & wmask);
    wire bvalid_next = do_wr || (bvalid && !bready);
    wire aw_hold_next = aw_have && !do_wr;
    wire w_hold_next = w_have && !do_wr;

    wire ar_fire = arvalid && arready;
    wire ra_ok = araddr[31:19] == 13'h0000 && araddr[1:0] == 2'b00;
    wire [16:0] ri = araddr[18:2];
    wire rvalid_next = ar_fire || (rvalid && !rready);
    wire r_hit = ra_ok && (ri == PIE_IDX_SYSVEC || ri == PIE_IDX_GRPB
        || ri == PIE_IDX_GRPC || ri == PIE_IDX_GMASK || ri == PIE_IDX_LMASK
        || ri == PIE_IDX_SRCEN || ri == PIE_IDX_PEND);
    logic [31:0] rd_mux;
    always_comb
    begin
        if (!ra_ok)
            rd_mux = 32'h00000000;
        else if (ri == PIE_IDX_SYSVEC)
            rd_mux = {16'h0000, sysvec_reg};
        else if (ri == PIE_IDX_GRPB)
            rd_mux = {16'h0000, grpb_reg};
        else if (ri == PIE_IDX_GRPC)
            rd_mux = {16'h0000, grpc_reg};
        else if (ri == PIE_IDX_GMASK)
            rd_mux = {31'h0, gmask_reg};
        else if (ri == PIE_IDX_LMASK)
            rd_mux = {25'h0, lmask_reg};
        else if (ri == PIE_IDX_SRCEN)
            rd_mux = {12'h000, srcen_reg};
        else if (ri == PIE_IDX_PEND)
            rd_mux = {12'h000, pend_reg};
        else
            rd_mux = 32'h00000000;
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pend_reg <= '0;
            srcen_reg <= PIE_SRCEN_RST;
            lmask_reg <= PIE_LMASK_RST;
            gmask_reg <= PIE_GMASK_RST; // see RULE_18
            sysvec_reg <= PIE_VEC_RST;
            grpb_reg <= PIE_VEC_RST;
            grpc_reg <= PIE_VEC_RST;
            level_req <= 7'h00;
            branch <= '0;
            global_mask_bit <= PIE_GMASK_RST;
        end
        else if (ce)
        begin
            // New event wins over the acknowledge clear
            pend_reg <= src_in | (pend_reg & ~grant); // see RULE_01 see RULE_20
            if (wr_srcen)
                srcen_reg <= se_new[PIE_NSRC-1:0];
            if (wr_lmask)
                lmask_reg <= lm_new[6:0];
            // Hardware set beats a software clear in the same cycle
            if (ack_ok || (sw_fire && !sw.trap))
                gmask_reg <= 1'b1; // see RULE_18 see RULE_12
            else if (wr_gmask)
                gmask_reg <= gm_new[PIE_GMASK_POS];
            global_mask_bit <= (ack_ok || (sw_fire && !sw.trap)) ? 1'b1
                : (wr_gmask ? gm_new[PIE_GMASK_POS] : gmask_reg);
            if (load_sys)
                sysvec_reg <= vec_load;
            if (load_b)
                grpb_reg <= vec_load;
            if (load_c)
                grpc_reg <= vec_load;
            level_req <= lvl_next;
            branch.valid <= ack_ok || sw_fire; // see RULE_04
            if (ack_ok)
                branch.addr <= PIE_LVL_VEC[ack.level - 3'h1]; // see RULE_04 see RULE_11
            else if (sw_fire)
                branch.addr <= sw.trap ? PIE_TRAP_VEC : swi_addr; // see RULE_12 see RULE_14
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= 32'h00000000;
            wdata_reg <= 32'h00000000;
            wstrb_reg <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= PIE_RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= PIE_RESP_OKAY;
        end
        else if (ce)
        begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            if (aw_fire)
                awaddr_reg <= awaddr;
            if (w_fire)
            begin
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            awready <= !aw_hold_next && !bvalid_next;
            wready <= !w_hold_next && !bvalid_next;
            bvalid <= bvalid_next;
            if (do_wr)
                bresp <= wr_hit ? PIE_RESP_OKAY : PIE_RESP_SLVERR;
            arready <= !rvalid_next;
            rvalid <= rvalid_next;
            if (ar_fire)
            begin
                rdata <= rd_mux;
                rresp <= r_hit ? PIE_RESP_OKAY : PIE_RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    gmask_on_ack_a: assert property (ack_ok |=> gmask_reg && global_mask_bit) // see RULE_18
        else $error("global mask not set by acknowledge");
    trap_vector_a: assert property (sw_go && sw.trap && !wr_gmask // see RULE_12
        |=> branch.valid && branch.addr == PIE_TRAP_VEC && gmask_reg == $past(gmask_reg))
        else $error("trap vector or mask wrong");
    swi_vector_a: assert property (sw_go && !sw.trap && sw.num == PIE_SWI_LAST // see RULE_14
        |=> branch.valid && branch.addr == 16'h0020)
        else $error("software interrupt vector wrong");
    level_vector_a: assert property (ack_ok && ack.level == PIE_LVL_GRPC // see RULE_04
        |=> branch.valid && branch.addr == 16'h0008)
        else $error("level branch address wrong");
    phantom_load_a: assert property (ack_ok && ack.level == PIE_LVL_GRPB // see RULE_19
        && (live & lvl_map[3]) == '0 |=> grpb_reg == PIE_PHANTOM)
        else $error("phantom offset not loaded");
    capture_offset_a: assert property (ack_ok && ack.level == PIE_LVL_GRPC // see RULE_07
        && live[9:8] == 2'b10 |=> grpc_reg == 16'h0034 && (!pend_reg[9] || $past(capture2_irq)))
        else $error("capture offset or clear wrong");
    level_gate_a: assert property (level_req[2] |-> $past(!gmask_reg && lmask_reg[2])) // see RULE_16
        else $error("level request while masked");
    level_hold_a: assert property (ce && !gmask_reg && lmask_reg[3] // see RULE_21
        && |(live & lvl_map[4]) |=> level_req[3])
        else $error("level request missing");
    converter_sys_a: assert property (ack_ok && ack.level == PIE_LVL_SYS_HI // see RULE_09
        && live[15] |=> sysvec_reg == 16'h0004)
        else $error("converter offset wrong");

    phantom_c: cover property (ack_ok && !win_any);
    trap_c: cover property (sw_go && sw.trap);
    grpb_win_c: cover property (level_req[2] ##[1:20] (ack_ok && ack.level == PIE_LVL_GRPB));
endmodule

// file: pie_core_model.sv
`timescale 1ns/10ps
module pie_core_model
    import pie_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Expander side
    input wire logic [6:0] level_req,
    input wire pie_pkg::pie_branch_t branch,
    output pie_pkg::pie_ack_t ack,
    // Bench control
    input wire logic auto_en,
    input wire logic [3:0] dly,
    input wire pie_pkg::pie_ack_t frc
);
    logic [3:0] cnt_reg;
    logic busy_reg;
    pie_ack_t auto_reg;
    logic [2:0] best;
    // Lowest numbered raised level wins
    always_comb
    begin
        best = 3'h0;
        for (int k = 6; k >= 0; k--)
            if (level_req[k]) best = 3'(k + 1);
    end
    // Waits for the branch so a stale request is never acked twice
    always_ff @(posedge aclk)
    begin
        auto_reg <= '0;
        if (!aresetn)
        begin
            cnt_reg <= 4'h0;
            busy_reg <= 1'b0;
        end
        else if (busy_reg)
            busy_reg <= !branch.valid;
        else if (auto_en && best != 3'h0 && cnt_reg == dly)
        begin
            auto_reg <= {1'b1, best};
            busy_reg <= 1'b1;
            cnt_reg <= 4'h0;
        end
        else
            cnt_reg <= (auto_en && best != 3'h0) ? cnt_reg + 4'h1 : 4'h0;
    end
    assign ack = frc.valid ? frc : auto_reg;
endmodule

// file: pie_expander_tb.sv
`timescale 1ns/10ps
module pie_expander_tb;
    import pie_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [19:0] src = '0;
    pie_sw_t sw = '0;
    pie_ack_t frc = '0;
    pie_ack_t ack;
    logic auto_en = 1'b0;
    logic [6:0] level_req;
    pie_branch_t branch;
    logic global_mask_bit;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] seed = 32'h36;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;

    always #50 aclk = ~aclk;

    pie_expander dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .timer2_period_irq(src[0]), .timer2_compare_irq(src[1]),
        .timer2_underflow_irq(src[2]), .timer2_overflow_irq(src[3]),
        .timer3_period_irq(src[4]), .timer3_compare_irq(src[5]),
        .timer3_underflow_irq(src[6]), .timer3_overflow_irq(src[7]),
        .capture1_irq(src[8]), .capture2_irq(src[9]), .capture3_irq(src[10]),
        .capture4_irq(src[11]), .serial_periph_irq(src[12]), .receiver_irq(src[13]),
        .transmitter_irq(src[14]), .converter_done_irq(src[15]), .ext_pin1_irq(src[16]),
        .ext_pin2_irq(src[17]), .ext_pin3_irq(src[18]), .analysis_irq(src[19]),
        .ack(ack), .sw(sw), .level_req(level_req), .branch(branch),
        .global_mask_bit(global_mask_bit), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1));

    pie_core_model core (.aclk(aclk), .aresetn(aresetn), .level_req(level_req),
        .branch(branch), .ack(ack), .auto_en(auto_en), .dly(4'h3), .frc(frc));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [2:0] lvl_of(input int i);
        return (i < 8) ? 3'h3 : (i < 12) ? 3'h4 : (i < 15) ? 3'h5 : (i < 19) ? 3'h6 : 3'h7;
    endfunction
    function automatic logic [15:0] off_of(input int i);
        logic [15:0] t [8] = '{16'h0005, 16'h0006, 16'h0007, 16'h0004,
            16'h0001, 16'h0011, 16'h001F, 16'h0000};
        return (i < 12) ? 16'h002B + 16'(i) : t[i - 12];
    endfunction
    function automatic logic [31:0] vaddr(input int l);
        logic [16:0] x;
        x = (l == 3) ? PIE_IDX_GRPB : (l == 4) ? PIE_IDX_GRPC : PIE_IDX_SYSVEC;
        return {13'h0000, x, 2'h0};
    endfunction
    function automatic logic [6:0] req_of(input logic [19:0] m);
        logic [6:0] r;
        r = '0;
        for (int i = 0; i < 20; i++)
            if (m[i]) r[lvl_of(i) - 1] = 1'b1;
        return r;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Ready may only drop after its item is taken, so watch it per edge
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready && !ad) awvalid <= 1'b0;
            if (wready && !wd) wvalid <= 1'b0;
            ad = ad | awready;
            wd = wd | wready;
        end while (!(ad && wd && bvalid));
        r = bresp;
    endtask
    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ad;
        ad = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready && !ad) arvalid <= 1'b0;
            ad = ad | arready;
        end while (!(ad && rvalid));
        d = rdata;
        r = rresp;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_wr(a, d, r);
    endtask
    task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        axi_rd(a, d, r);
        chk(nm, e, d);
        chk("rresp", PIE_RESP_OKAY, r);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic pulse(input logic [19:0] m);
        src <= m;
        @(posedge aclk);
        src <= '0;
        tick(3);
    endtask
    task automatic fire(input pie_ack_t a, input pie_sw_t s);
        frc <= a;
        sw <= s;
        @(posedge aclk);
        frc <= '0;
        sw <= '0;
        @(posedge aclk);
    endtask
    task automatic serve(input logic [2:0] l, input logic [15:0] e);
        fire({1'b1, l}, '0);
        chk("branch", {15'h0, 1'b1, 12'h0, l, 1'b0}, {15'h0, branch});
        chk("gmask_ack", 1, global_mask_bit);
        if (l > 3'h2 && l < 3'h7) rchk("vector", vaddr(l), {16'h0000, e});
    endtask

    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            complete_run();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        logic [19:0] m;
        logic [31:0] d;
        logic [1:0] r;
        int j;
        tick(12);
        aresetn <= 1'b1;
        tick(2);
        chk("gmask_rst", 1, global_mask_bit);
        chk("req_rst", 0, level_req);
        rchk("gmask_reg", 32'h40, 1);
        rchk("lmask_reg", 32'h44, 0);
        rchk("srcen_reg", 32'h48, 0);
        for (int l = 3; l < 6; l++) rchk("vec_rst", vaddr(l), 0);
        axi_rd(32'h100, d, r);
        chk("rresp_bad", PIE_RESP_SLVERR, r);
        axi_wr(32'h100, 0, r);
        chk("bresp_bad", PIE_RESP_SLVERR, r);
        axi_wr(vaddr(5), 32'hFFFF, r);
        chk("bresp_ro", PIE_RESP_OKAY, r);
        rchk("vec_ro", vaddr(5), 0);
        $display("reset test done");
        wr(32'h48, 32'hFFFFF);
        wr(32'h44, 32'h7F);
        pulse(20'h1);
        chk("req_gmask", 0, level_req);
        wr(32'h40, 0);
        tick(2);
        chk("req_open", 7'h04, level_req);
        wr(32'h44, 32'h7B);
        tick(2);
        chk("req_lmask", 0, level_req);
        wr(32'h44, 32'h7F);
        serve(3'h3, 16'h002B);
        $display("mask test done");
        for (int i = 0; i < 20; i++)
        begin
            wr(32'h40, 0);
            pulse(20'(1) << i);
            chk("req_one", 32'(7'(1) << (lvl_of(i) - 1)), level_req);
            serve(lvl_of(i), off_of(i));
            rchk("pending", 32'h4C, 0);
        end
        $display("source table test done");
        repeat (6)
        begin
            m = 20'(rnd());
            pulse(m);
            while (m != 0)
            begin
                wr(32'h40, 0);
                tick(2);
                chk("req_mix", req_of(m), level_req);
                j = 0;
                while (!m[j]) j++;
                serve(lvl_of(j), off_of(j));
                m[j] = 1'b0;
            end
        end
        $display("priority test done");
        wr(32'h48, 32'hFFFFE);
        pulse(20'h1);
        serve(3'h3, PIE_PHANTOM);
        rchk("pend_kept", 32'h4C, 1);
        serve(3'h6, PIE_PHANTOM);
        wr(32'h48, 32'hFFFFF);
        serve(3'h3, 16'h002B);
        ce <= 1'b0;
        fire({1'b1, 3'h4}, '0);
        ce <= 1'b1;
        chk("ce_hold", 0, branch.valid);
        $display("phantom test done");
        wr(32'h40, 0);
        fire('0, {1'b1, 1'b1, 5'h00});
        chk("trap", {15'h0, 1'b1, 16'h0022}, {15'h0, branch});
        chk("gmask_trap", 0, global_mask_bit);
        for (int n = 8; n < 17; n++)
        begin
            fire('0, {1'b1, 1'b0, 5'(n)});
            chk("swi", {15'h0, 1'b1, 16'h0010 + 16'(2 * (n - 8))}, {15'h0, branch});
            chk("gmask_swi", 1, global_mask_bit);
        end
        fire('0, {1'b1, 1'b0, 5'h07});
        chk("swi_bad", 0, branch.valid);
        $display("software test done");
        auto_en <= 1'b1;
        wr(32'h40, 0);
        pulse(20'h00100);
        j = 0;
        while (!branch.valid && j < 40)
        begin
            @(posedge aclk);
            j++;
        end
        chk("auto_branch", {15'h0, 1'b1, 16'h0008}, {15'h0, branch});
        auto_en <= 1'b0;
        rchk("auto_vec", vaddr(4), 32'h0033);
        $display("core model test done");
        complete_run();
    end
endmodule
